// ==== core/qlsc_pkg.sv ====
// Purpose: Shared constants of the quad low-side switch control block
// Assumes: mclk at 100 MHz
// Notes: SPI register codes and bus offsets are local to this block
`default_nettype none
package qlsc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RESTART_TIME_US = 10;
  localparam int RETRY_CYCLES = RESTART_TIME_US * CLK_MHZ;
  localparam int RETRY_W = 10;
  localparam logic [RETRY_W-1:0] RETRY_LAST = RETRY_W'(RETRY_CYCLES - 1);
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 4;
  localparam int WR_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 12;
  localparam int NCH = 4;
  localparam logic [2:0] SA_OUT = 3'h0;
  localparam logic [2:0] SA_MAP0 = 3'h1;
  localparam logic [2:0] SA_MAP1 = 3'h2;
  localparam logic [2:0] SA_PROBE = 3'h3;
  localparam logic [2:0] SA_DIAG = 3'h4;
  localparam logic [2:0] SA_MON = 3'h5;
  localparam logic [2:0] SA_SHUT = 3'h6;
  localparam logic [3:0] OUT_RST = 4'h0;
  localparam logic [3:0] MAP0_RST = 4'h4;
  localparam logic [3:0] MAP1_RST = 4'h8;
  localparam logic [3:0] PROBE_RST = 4'h0;
  // ----------------------------------------
  // Bus map and interrupt bits
  // ----------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_ST = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam int IRQ_W = 4;
  localparam int EV_OVL = 0;
  localparam int EV_OT = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_FS = 3;
  localparam int SYNC_W = 19;
endpackage : qlsc_pkg
`default_nettype wire

// ==== core/qlsc_sync.sv ====
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: inputs are levels, slow against mclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module qlsc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : qlsc_sync
`default_nettype wire

// ==== core/qlsc_spi.sv ====
// Purpose: 16-bit SPI slave shifter, mode 0, sampled by mclk
// Assumes: sclk, cs_n, si already synchronised to mclk
// Notes: sclk must stay below a quarter of mclk
`timescale 1ns/1ps
`default_nettype none
module qlsc_spi (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [15:0] resp_word,
  output logic frame_start,
  output logic frame_valid,
  output logic [15:0] frame_word,
  output logic so,
  output logic so_oe
);
  logic sclk_d;
  logic cs_d;
  logic si_hold;
  logic any_bits;
  logic [qlsc_pkg::CNT_W-1:0] bit_cnt;
  wire rise = sclk & ~sclk_d & ~cs_n;
  wire fall = ~sclk & sclk_d & ~cs_n;
  wire cs_fall = ~cs_n & cs_d;
  wire cs_rise = cs_n & ~cs_d;

  // ----------------------------------------
  // Shift path
  // ----------------------------------------
  // Shift-through keeps the chain working with 16-bit neighbours; an 8-bit neighbour leaves the frame off word and rejected
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      si_hold <= 1'b0;
      frame_word <= 16'h0000;
      bit_cnt <= '0;
      any_bits <= 1'b0;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
      if (rise) si_hold <= si;
      if (cs_fall) begin
        frame_word <= resp_word;
        bit_cnt <= '0;
        any_bits <= 1'b0;
      end else if (fall) begin
        frame_word <= {frame_word[14:0], si_hold};
        bit_cnt <= bit_cnt + 1'b1;
        any_bits <= 1'b1;
      end
    end
  end

  // Frame counts only on whole 16-bit words at deselect
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_valid <= 1'b0;
      frame_start <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      frame_valid <= cs_rise & any_bits & (bit_cnt == '0);
      frame_start <= cs_fall;
      so_oe <= ~cs_n;
    end
  end

  assign so = frame_word[15];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_so_quiet;
    cs_n && $past(cs_n) |-> !so_oe;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("SO driven while deselected");

  property p_whole_words;
    frame_valid |-> $past(bit_cnt) == '0 && $past(any_bits) && $past(cs_n, 2) == 1'b0;
  endproperty
  a_whole_words: assert property (p_whole_words) else $error("Frame accepted off word");
endmodule : qlsc_spi
`default_nettype wire

// ==== core/qlsc_top.sv ====
// Purpose: Control and protection logic of a four-channel low-side switch
// Assumes: pins are asynchronous to mclk; Wishbone master on mclk
// Notes: channel drive, probe enables and monitor bits face the analog side
// Operation
// - Sixteen-bit SPI frames carry control and diagnosis
// - Serial port shifts through for daisy chains
// - Exactly four low-side channels, numbered 0 to 3
// - Inputs drive channels through programmable input map
// - Fail-safe routes inputs to channels 2 and 3
// - Low power request gives inputs channels 2, 3
// - Serial access only while digital supply present
// - Overload latches channel off until serial re-enable
// - Fail-safe overload restarts after fallback restart time
// - Over-temperature latches channel off
// - Serial probe enable; off-state output monitor bits
// - Diagnosis latched until read over serial
// - Serial output released while chip select high
// - Reset map and fail-safe: input 0 drives channel 2, input 1 channel 3
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module qlsc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic spi_sclk,
  input wire logic chip_select_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic parallel_input_0,
  input wire logic parallel_input_1,
  input wire logic power_request,
  input wire logic vdd_present,
  input wire logic [3:0] overload_trip,
  input wire logic [3:0] overtemp,
  input wire logic [3:0] drain_level,
  output logic [3:0] channel_on,
  output logic [3:0] probe_enable
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [qlsc_pkg::SYNC_W-1:0] sync_q;
  qlsc_sync #(.W(qlsc_pkg::SYNC_W)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d({drain_level, overtemp, overload_trip, vdd_present, power_request,
        parallel_input_1, parallel_input_0, spi_si, chip_select_n, spi_sclk}),
    .q(sync_q)
  );
  wire sclk_s = sync_q[0];
  wire cs_s = sync_q[1];
  wire si_s = sync_q[2];
  wire in0_s = sync_q[3];
  wire in1_s = sync_q[4];
  wire pwr_s = sync_q[5];
  wire vdd_s = sync_q[6];
  wire [3:0] ovl_s = sync_q[10:7];
  wire [3:0] ot_s = sync_q[14:11];
  wire [3:0] output_monitor_bits = sync_q[18:15];

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic frame_start;
  logic frame_valid;
  logic [15:0] frame_word;
  logic [15:0] resp_word;
  logic so_q;
  logic so_oe_q;
  // No supply looks like a permanently deselected port
  wire cs_eff = cs_s | ~vdd_s;

  qlsc_spi u_spi (
    .mclk(mclk),
    .arst_n(arst_n),
    .sclk(sclk_s),
    .cs_n(cs_eff),
    .si(si_s),
    .resp_word(resp_word),
    .frame_start(frame_start),
    .frame_valid(frame_valid),
    .frame_word(frame_word),
    .so(so_q),
    .so_oe(so_oe_q)
  );
  assign spi_so = so_q;
  assign spi_so_oe = so_oe_q & ~cs_eff;

  // ----------------------------------------
  // Serial registers
  // ----------------------------------------
  logic [3:0] out_ctrl;
  logic [3:0] map0;
  logic [3:0] map1;
  logic [3:0] probe_ctrl;
  logic [2:0] last_addr;
  logic [3:0] ovl_off;
  logic [3:0] ot_off;
  logic [3:0] diag_ovl;
  logic [3:0] diag_ot;
  wire [2:0] s_addr = frame_word[qlsc_pkg::ADDR_HI:qlsc_pkg::ADDR_LO];
  wire s_wr = frame_valid & frame_word[qlsc_pkg::WR_POS];
  wire [3:0] s_data = frame_word[3:0];
  wire wr_out = s_wr & (s_addr == qlsc_pkg::SA_OUT);
  wire [3:0] reenable = wr_out ? s_data : 4'h0;
  wire diag_rd = frame_start & (last_addr == qlsc_pkg::SA_DIAG);
  wire fail_safe = ~pwr_s;
  logic [7:0] s_rdata;

  always_comb begin
    case (last_addr)
      qlsc_pkg::SA_OUT: s_rdata = {4'h0, out_ctrl};
      qlsc_pkg::SA_MAP0: s_rdata = {4'h0, map0};
      qlsc_pkg::SA_MAP1: s_rdata = {4'h0, map1};
      qlsc_pkg::SA_PROBE: s_rdata = {4'h0, probe_ctrl};
      qlsc_pkg::SA_DIAG: s_rdata = {diag_ot, diag_ovl};
      qlsc_pkg::SA_MON: s_rdata = {4'h0, output_monitor_bits};
      qlsc_pkg::SA_SHUT: s_rdata = {ot_off, ovl_off};
      default: s_rdata = 8'h00;
    endcase
  end
  assign resp_word = {channel_on, fail_safe, 3'h0, s_rdata};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_ctrl <= qlsc_pkg::OUT_RST;
      map0 <= qlsc_pkg::MAP0_RST;
      map1 <= qlsc_pkg::MAP1_RST;
      probe_ctrl <= qlsc_pkg::PROBE_RST;
      last_addr <= qlsc_pkg::SA_OUT;
    end else if (frame_valid) begin
      last_addr <= s_addr;
      if (s_wr) begin
        case (s_addr)
          qlsc_pkg::SA_OUT: out_ctrl <= s_data;
          qlsc_pkg::SA_MAP0: map0 <= s_data;
          qlsc_pkg::SA_MAP1: map1 <= s_data;
          qlsc_pkg::SA_PROBE: probe_ctrl <= s_data;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Channel control and protection
  // ----------------------------------------
  wire [3:0] fs_req = {in1_s, in0_s, 2'b00};
  wire [3:0] map_req = out_ctrl | (map0 & {4{in0_s}}) | (map1 & {4{in1_s}});
  wire [3:0] req = fail_safe ? fs_req : map_req;
  wire [3:0] ovl_set = ovl_s & channel_on;
  wire [3:0] ot_set = ot_s;
  logic [3:0] retry_hit;
  wire [3:0] ovl_clr = reenable | retry_hit;
  wire [3:0] next_ovl_off = (ovl_off & ~ovl_clr) | ovl_set;
  wire [3:0] next_ot_off = (ot_off & ~reenable) | ot_set;
  wire [3:0] next_channel_on = req & ~next_ovl_off & ~next_ot_off;
  logic [qlsc_pkg::RETRY_W-1:0] retry_cnt [qlsc_pkg::NCH];

  // Retry waits only while the fail-safe routed input keeps asking for the channel
  genvar k;
  generate
    for (k = 0; k < qlsc_pkg::NCH; k++) begin : g_retry
      wire wait_k = fail_safe & ovl_off[k] & fs_req[k];
      assign retry_hit[k] = wait_k & (retry_cnt[k] == qlsc_pkg::RETRY_LAST);
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          retry_cnt[k] <= '0;
        end else if (wait_k && !retry_hit[k]) begin
          retry_cnt[k] <= retry_cnt[k] + 1'b1;
        end else begin
          retry_cnt[k] <= '0;
        end
      end
    end
  endgenerate

  // Set wins over clear so a new fault is never lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovl_off <= 4'h0;
      ot_off <= 4'h0;
      channel_on <= 4'h0;
      probe_enable <= 4'h0;
      diag_ovl <= 4'h0;
      diag_ot <= 4'h0;
    end else begin
      ovl_off <= next_ovl_off;
      ot_off <= next_ot_off;
      channel_on <= next_channel_on;
      probe_enable <= probe_ctrl & ~next_channel_on;
      diag_ovl <= (diag_ovl & ~{4{diag_rd}}) | ovl_set;
      diag_ot <= (diag_ot & ~{4{diag_rd}}) | ot_set;
    end
  end

  // ----------------------------------------
  // Wishbone slave and interrupts
  // ----------------------------------------
  logic [qlsc_pkg::IRQ_W-1:0] irq_st;
  logic [qlsc_pkg::IRQ_W-1:0] irq_en;
  logic fs_d;
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire hit_status = wb_adr_i[7:2] == qlsc_pkg::OFF_STATUS[7:2];
  wire hit_irq_st = wb_adr_i[7:2] == qlsc_pkg::OFF_IRQ_ST[7:2];
  wire hit_irq_clr = wb_adr_i[7:2] == qlsc_pkg::OFF_IRQ_CLR[7:2];
  wire hit_irq_en = wb_adr_i[7:2] == qlsc_pkg::OFF_IRQ_EN[7:2];
  wire [qlsc_pkg::IRQ_W-1:0] irq_clr = (wb_wr & hit_irq_clr) ?
                                       wb_dat_i[qlsc_pkg::IRQ_W-1:0] : '0;
  wire [qlsc_pkg::IRQ_W-1:0] ev = {fail_safe & ~fs_d, frame_valid, |(ot_set & ~ot_off),
                                   |ovl_set};
  wire [31:0] status_word = {16'h0000, in1_s, in0_s, vdd_s, fail_safe,
                             ot_off, ovl_off, channel_on};
  wire [31:0] wb_rd = hit_status ? status_word :
                      hit_irq_st ? {28'h0000000, irq_st} :
                      hit_irq_en ? {28'h0000000, irq_en} : 32'h00000000;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o) wb_dat_o <= wb_we_i ? 32'h00000000 : wb_rd;
    end
  end

  // A new event in the clearing cycle stays set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st <= '0;
      irq_en <= '0;
      fs_d <= 1'b1; // Pins read as fail-safe until synchronised; no false entry event
      irq <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~irq_clr) | ev;
      if (wb_wr && hit_irq_en) irq_en <= wb_dat_i[qlsc_pkg::IRQ_W-1:0];
      fs_d <= fail_safe;
      irq <= |(irq_st & irq_en);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_ovl_trip;
    (ovl_s & channel_on) != 4'h0;
  endsequence

  property p_ovl_latch;
    logic [3:0] t;
    (s_ovl_trip, t = ovl_s & channel_on) |=> (ovl_off & t) == t && (channel_on & t) == 4'h0;
  endproperty
  a_ovl_latch: assert property (p_ovl_latch) else $error("Overload did not latch off");

  property p_off_held;
    (channel_on & (ovl_off | ot_off)) == 4'h0;
  endproperty
  a_off_held: assert property (p_off_held) else $error("Latched channel is on");

  property p_only_write_clears;
    ((~ovl_off & $past(ovl_off)) & ~$past(reenable) & ~$past(retry_hit)) == 4'h0;
  endproperty
  a_only_write_clears: assert property (p_only_write_clears) else $error("Shutdown self-cleared");

  property p_fs_route;
    fail_safe && $past(fail_safe) |-> channel_on[1:0] == 2'b00 &&
      channel_on[3:2] == ($past({in1_s, in0_s}) & ~ovl_off[3:2] & ~ot_off[3:2]);
  endproperty
  a_fs_route: assert property (p_fs_route) else $error("Fail-safe routing wrong");

  sequence s_retry_due;
    fail_safe && retry_hit != 4'h0;
  endsequence

  property p_retry;
    logic [3:0] t;
    (s_retry_due, t = retry_hit) |=> (ovl_off & t) == 4'h0;
  endproperty
  a_retry: assert property (p_retry) else $error("Fail-safe restart missed");

  property p_no_supply;
    !vdd_s && $past(!vdd_s) |-> !frame_valid && !spi_so_oe;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("Serial active without supply");

  property p_diag_hold;
    ((($past(diag_ovl) & ~diag_ovl) | ($past(diag_ot) & ~diag_ot)) != 4'h0) |-> $past(diag_rd);
  endproperty
  a_diag_hold: assert property (p_diag_hold) else $error("Diagnosis lost unread");

  property p_probe_off;
    (probe_enable & channel_on) == 4'h0;
  endproperty
  a_probe_off: assert property (p_probe_off) else $error("Probe on a driven channel");

  property p_map_write;
    s_wr && s_addr == qlsc_pkg::SA_MAP0 |=> map0 == $past(s_data);
  endproperty
  a_map_write: assert property (p_map_write) else $error("Input map not written");
endmodule : qlsc_top
`default_nettype wire

// ==== verification/qlsc_host.sv ====
// Purpose: Host model driving the serial port as a mode 0 master
// Assumes: link clock period 80 ns, clock low outside frames
// Notes: SI falls to its pull-down level between frames
`timescale 1ns/1ps
`default_nettype none
module qlsc_host #(
  parameter int HALF = 40 // Half link period; a slower host only widens margins
) (
  output logic spi_sclk,
  output logic chip_select_n,
  output logic spi_si,
  input wire logic spi_so
);
  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  initial begin
    spi_sclk = 1'h0;
    chip_select_n = 1'h1;
    spi_si = 1'h0;
  end
  // Sends the low n bits of tx MSB first; rx collects SO at each rising edge
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    #3;
    chip_select_n = 1'h0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      spi_si = tx[i];
      #HALF;
      spi_sclk = 1'h1;
      rx = {rx[30:0], spi_so};
      #HALF;
      spi_sclk = 1'h0;
    end
    #HALF;
    chip_select_n = 1'h1;
    spi_si = 1'h0;
    // Gap covers action latency and keeps frames whole mclk periods, off the clock edge
    #197;
  endtask : xfer
endmodule : qlsc_host
`default_nettype wire

// ==== verification/tb_qlsc_top.sv ====
// Purpose: Self-checking bench of the switch control block
// Assumes: host model on the serial port, Wishbone driven here
// Notes: fault and level pins stand in for the analog side
`timescale 1ns/1ps
`default_nettype none
module tb_qlsc_top;
  logic mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, overload_trip, overtemp, drain_level, channel_on, probe_enable;
  logic [31:0] wb_dat_i, wb_dat_o, r, rx;
  logic spi_sclk, chip_select_n, spi_si, spi_so, spi_so_oe;
  logic parallel_input_0, parallel_input_1, power_request, vdd_present;
  int n_errors, cmp_count;
  // A released serial output reads inverted, so a late or missing enable is caught
  wire so_line = spi_so_oe ? spi_so : ~spi_so;

  qlsc_top u_dut (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .spi_sclk, .chip_select_n, .spi_si, .spi_so,
    .spi_so_oe, .parallel_input_0, .parallel_input_1, .power_request, .vdd_present,
    .overload_trip, .overtemp, .drain_level, .channel_on, .probe_enable);
  qlsc_host u_host (.spi_sclk, .chip_select_n, .spi_si, .spi_so(so_line));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic st();
    repeat (8) @(posedge mclk);
  endtask : st
  // Classic cycle: waits for ack without assuming its latency
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) n_errors++;
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask : wb
  task automatic sw(input logic [2:0] a, input logic [3:0] d);
    u_host.xfer(16, {16'h0000, 1'h1, a, 8'h00, d}, rx);
  endtask : sw
  // Second frame returns the state picked by the first
  task automatic sr(input logic [2:0] a);
    u_host.xfer(16, {16'h0000, 1'h0, a, 12'h000}, rx);
    u_host.xfer(16, {16'h0000, 1'h0, a, 12'h000}, rx);
  endtask : sr

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(channel_on, 32'h0);
    chk(spi_so_oe, 32'h0);
    wb(1'h0, qlsc_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h2000);
    wb(1'h1, 8'h10, 32'hF);
    wb(1'h0, 8'h10, 32'h0);
    chk(r, 32'h0);
  endtask : t_reset
  task automatic t_out();
    sw(qlsc_pkg::SA_OUT, 4'hA);
    chk(channel_on, 32'hA);
    fork
      sr(qlsc_pkg::SA_OUT);
      begin
        #400;
        chk(spi_so_oe, 32'h1);
      end
    join
    chk(rx, 32'hA00A);
    chk(spi_so_oe, 32'h0);
    wb(1'h0, qlsc_pkg::OFF_IRQ_ST, 32'h0);
    chk(r[2], 32'h1);
  endtask : t_out
  task automatic t_chain();
    u_host.xfer(24, {8'h00, 8'hFF, 1'h1, qlsc_pkg::SA_OUT, 12'h005}, rx);
    chk(channel_on, 32'hA);
    u_host.xfer(32, {16'h1234, 1'h1, qlsc_pkg::SA_OUT, 12'h005}, rx);
    chk(rx[15:0], 32'h1234);
    chk(channel_on, 32'h5);
  endtask : t_chain
  task automatic t_map();
    sw(qlsc_pkg::SA_OUT, 4'h0);
    @(posedge mclk);
    parallel_input_0 <= 1'h1;
    st();
    chk(channel_on, 32'h4);
    parallel_input_1 <= 1'h1;
    st();
    chk(channel_on, 32'hC);
    sw(qlsc_pkg::SA_MAP0, 4'h3);
    chk(channel_on, 32'hB);
    sw(qlsc_pkg::SA_MAP0, 4'h4);
    parallel_input_0 <= 1'h0;
    parallel_input_1 <= 1'h0;
    st();
  endtask : t_map
  task automatic t_vdd();
    vdd_present <= 1'h0;
    st();
    sw(qlsc_pkg::SA_OUT, 4'hF);
    chk(channel_on, 32'h0);
    vdd_present <= 1'h1;
    st();
  endtask : t_vdd
  task automatic t_ovl();
    wb(1'h1, qlsc_pkg::OFF_IRQ_CLR, 32'hF);
    wb(1'h1, qlsc_pkg::OFF_IRQ_EN, 32'h1);
    sw(qlsc_pkg::SA_OUT, 4'h1);
    overload_trip <= 4'h1;
    st();
    chk(channel_on, 32'h0);
    overload_trip <= 4'h0;
    repeat (30) @(posedge mclk);
    chk(channel_on, 32'h0);
    chk(irq, 32'h1);
    wb(1'h1, qlsc_pkg::OFF_IRQ_EN, 32'h0);
    st();
    chk(irq, 32'h0);
    wb(1'h1, qlsc_pkg::OFF_IRQ_EN, 32'h1);
    st();
    chk(irq, 32'h1);
    wb(1'h1, qlsc_pkg::OFF_IRQ_CLR, 32'h1);
    st();
    chk(irq, 32'h0);
    sr(qlsc_pkg::SA_DIAG);
    chk(rx, 32'h0001);
    sr(qlsc_pkg::SA_DIAG);
    chk(rx, 32'h0000);
    sw(qlsc_pkg::SA_OUT, 4'h1);
    chk(channel_on, 32'h1);
  endtask : t_ovl
  task automatic t_ot();
    sw(qlsc_pkg::SA_OUT, 4'h3);
    overtemp <= 4'h2;
    st();
    chk(channel_on, 32'h1);
    overtemp <= 4'h0;
    st();
    sr(qlsc_pkg::SA_SHUT);
    chk(rx, 32'h1020);
    sw(qlsc_pkg::SA_OUT, 4'h2);
    chk(channel_on, 32'h2);
  endtask : t_ot
  task automatic t_probe();
    sw(qlsc_pkg::SA_OUT, 4'h0);
    sw(qlsc_pkg::SA_PROBE, 4'hF);
    chk(probe_enable, 32'hF);
    sw(qlsc_pkg::SA_OUT, 4'h1);
    chk(probe_enable, 32'hE);
    drain_level <= 4'h5;
    sr(qlsc_pkg::SA_MON);
    chk(rx, 32'h1005);
    sw(qlsc_pkg::SA_PROBE, 4'h0);
    sw(qlsc_pkg::SA_OUT, 4'h0);
  endtask : t_probe
  // Restart timing: still off well before the restart time, on soon after it
  task automatic t_fs();
    sw(qlsc_pkg::SA_MAP0, 4'h1);
    wb(1'h1, qlsc_pkg::OFF_IRQ_EN, 32'h8);
    power_request <= 1'h0;
    vdd_present <= 1'h0;
    parallel_input_0 <= 1'h1;
    st();
    chk(channel_on, 32'h4);
    chk(irq, 32'h1);
    overload_trip <= 4'h4;
    st();
    overload_trip <= 4'h0;
    chk(channel_on, 32'h0);
    repeat (850) @(posedge mclk);
    chk(channel_on, 32'h0);
    repeat (300) @(posedge mclk);
    chk(channel_on, 32'h4);
  endtask : t_fs

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
  initial begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, parallel_input_0, parallel_input_1} = '0;
    {wb_adr_i, wb_dat_i, overload_trip, overtemp, drain_level} = '0;
    wb_sel_i = 4'hF;
    power_request = 1'h1;
    vdd_present = 1'h1;
    repeat (6) @(posedge mclk);
    arst_n <= 1'h1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_out();
    t_chain();
    t_map();
    t_vdd();
    t_ovl();
    t_ot();
    t_probe();
    t_fs();
    stop_test();
  end
endmodule : tb_qlsc_top
`default_nettype wire
